// >>> inc/idfw_pkg.sv
/*
 * constants for the identification feature words slice (words 76 to 84):
 * word indices, rom addressing, bit positions and the fixed word values.
 * assumes the surrounding data port hands in a word index and a read strobe.
 */
// How it works
// - words 76 to 79 read as 0000h, reserved for the serial variant
// - major version bits 4-7 flag revisions 4-7; other bits reserved or obsolete
// - 0000h or FFFFh in words 80/81 means no version; both read 0000h
// - minor values 0001h to FFFEh count as a defined revision code
// - word 82 reads 7028h
// - word 82 bits flag NOP, buffers, protected area, reset, interrupts, caches, power
// - word 82 bit 4 always reads zero: packet feature set unsupported
// - words 83 and 84 read bit 15 zero and bit 14 one
// - word 83 reads 500Ch
// - word 83 bits flag flush, overlay, 48-bit, acoustic, power, queued, microcode
// - word 84 reads 4000h, only the validity bit set
// - word 84 bits flag unload, streaming, name, logging, pass-through, self-test
package idfw_pkg;

    // word indices of the slice
    localparam logic [7:0] IDX_FIRST = 8'h4c; // word 76
    localparam logic [7:0] IDX_RSV_LAST = 8'h4f; // word 79
    localparam logic [7:0] IDX_MAJOR = 8'h50; // word 80
    localparam logic [7:0] IDX_MINOR = 8'h51; // word 81
    localparam logic [7:0] IDX_CMD1 = 8'h52; // word 82
    localparam logic [7:0] IDX_CMD2 = 8'h53; // word 83
    localparam logic [7:0] IDX_EXT = 8'h54; // word 84
    localparam logic [7:0] IDX_LAST = 8'h54;

    // rom geometry
    localparam int ROM_WORDS = 9;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // rom addresses of the non-reserved words (index minus word 76)
    localparam logic [ADDR_W-1:0] ADR_MAJOR = 4'h4;
    localparam logic [ADDR_W-1:0] ADR_MINOR = 4'h5;
    localparam logic [ADDR_W-1:0] ADR_CMD1 = 4'h6;
    localparam logic [ADDR_W-1:0] ADR_CMD2 = 4'h7;
    localparam logic [ADDR_W-1:0] ADR_EXT = 4'h8;

    // version word meanings
    localparam logic [15:0] VER_NONE_ZERO = 16'h0000;
    localparam logic [15:0] VER_NONE_ONES = 16'hffff;
    localparam int MAJ_REV_LO = 4; // bit of the lowest flagged revision
    localparam int MAJ_REV_HI = 7; // bit of the highest flagged revision

    // word 82 bit positions
    localparam int C1_NOP = 14;
    localparam int C1_RD_BUF = 13;
    localparam int C1_WR_BUF = 12;
    localparam int C1_HPA = 10;
    localparam int C1_DEV_RST = 9;
    localparam int C1_SVC_IRQ = 8;
    localparam int C1_REL_IRQ = 7;
    localparam int C1_LOOKAHEAD = 6;
    localparam int C1_WCACHE = 5;
    localparam int C1_PACKET = 4;
    localparam int C1_PWR_MGMT = 3;
    localparam int C1_REMOVABLE = 2;
    localparam int C1_SECURITY = 1;
    localparam int C1_SMART = 0;

    // word 83 / 84 validity signature positions
    localparam int SIG_ZERO_BIT = 15;
    localparam int SIG_ONE_BIT = 14;

    // word 83 bit positions
    localparam int C2_FLUSH_EXT = 13;
    localparam int C2_FLUSH = 12;
    localparam int C2_OVERLAY = 11;
    localparam int C2_ADDR48 = 10;
    localparam int C2_ACOUSTIC = 9;
    localparam int C2_SETMAX_SEC = 8;
    localparam int C2_SPINUP_REQ = 6;
    localparam int C2_PUIS = 5;
    localparam int C2_RMSN = 4;
    localparam int C2_APM = 3;
    localparam int C2_CFA = 2;
    localparam int C2_QUEUED = 1;
    localparam int C2_MICROCODE = 0;

    // word 84 bit positions
    localparam int EX_UNLOAD = 13;
    localparam int EX_URG_WR = 10;
    localparam int EX_URG_RD = 9;
    localparam int EX_WWN64 = 8;
    localparam int EX_FUA_Q = 7;
    localparam int EX_FUA = 6;
    localparam int EX_GPL = 5;
    localparam int EX_STREAM = 4;
    localparam int EX_PASSTHRU = 3;
    localparam int EX_MSN = 2;
    localparam int EX_SELFTEST = 1;

    // fixed word values
    localparam logic [15:0] VAL_RESERVED = 16'h0000;
    localparam logic [15:0] VAL_MAJOR = 16'h0000;
    localparam logic [15:0] VAL_MINOR = 16'h0000;
    localparam logic [15:0] VAL_CMD1 = 16'h7028; // nop, buffers, write cache, power mgmt
    localparam logic [15:0] VAL_CMD2 = 16'h500c; // signature, flush, apm, cfa
    localparam logic [15:0] VAL_EXT = 16'h4000; // signature only

    // controller states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_FETCH = 3'h2,
        ST_ANSWER = 3'h4
    } idfw_state_t;

endpackage

// >>> hw/idfw_rom.sv
/*
 * read-only table holding the nine fixed words of the slice.
 * assumes the caller presents an in-range address with rd_en; data is registered.
 */
module idfw_rom (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // read port
    input wire logic rd_en,
    input wire logic [idfw_pkg::ADDR_W-1:0] addr,
    output logic [idfw_pkg::DATA_W-1:0] data_q
);

    logic [idfw_pkg::DATA_W-1:0] data_d;

    // constant contents; no write path exists
    always_comb begin
        data_d = data_q;
        if (rd_en) begin
            case (addr)
                idfw_pkg::ADR_MAJOR: data_d = idfw_pkg::VAL_MAJOR;
                idfw_pkg::ADR_MINOR: data_d = idfw_pkg::VAL_MINOR;
                idfw_pkg::ADR_CMD1: data_d = idfw_pkg::VAL_CMD1;
                idfw_pkg::ADR_CMD2: data_d = idfw_pkg::VAL_CMD2;
                idfw_pkg::ADR_EXT: data_d = idfw_pkg::VAL_EXT;
                default: data_d = idfw_pkg::VAL_RESERVED;
            endcase
        end
    end

    // registered read data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_q <= idfw_pkg::VAL_RESERVED;
        end else begin
            data_q <= data_d;
        end
    end

endmodule // idfw_rom

// >>> hw/idfw_top.sv
/*
 * identification feature words slice: answers reads of words 76 to 84
 * with fixed values and flags version and feature status of the answer.
 * assumes rd_req, wr_req and word_idx come from logic on the same clock,
 * one-cycle strobes with the index valid alongside.
 */
module idfw_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // read request
    input wire logic rd_req,
    input wire logic [7:0] word_idx,
    // write attempt
    input wire logic wr_req,
    input wire logic [15:0] wr_data,
    // read answer
    output logic rd_ack_q,
    output logic [15:0] rd_data_q,
    output logic rd_hit_q,
    output logic busy_q,
    // write answer
    output logic wr_reject_q,
    // decoded status of the last answer
    output logic ver_reported_q,
    output logic minor_rev_q,
    output logic sig_ok_q,
    output logic [3:0] major_revs_q
);

    // true when the index falls inside this slice
    function automatic logic idfw_in_slice(input logic [7:0] idx);
        idfw_in_slice = (idx >= idfw_pkg::IDX_FIRST) && (idx <= idfw_pkg::IDX_LAST);
    endfunction

    // rom address of an index inside the slice
    function automatic logic [idfw_pkg::ADDR_W-1:0] idfw_to_addr(input logic [7:0] idx);
        logic [7:0] diff;
        diff = idx - idfw_pkg::IDX_FIRST;
        idfw_to_addr = diff[idfw_pkg::ADDR_W-1:0];
    endfunction

    // version word reports nothing when all zeros or all ones
    function automatic logic idfw_ver_none(input logic [15:0] w);
        idfw_ver_none = (w == idfw_pkg::VER_NONE_ZERO) || (w == idfw_pkg::VER_NONE_ONES);
    endfunction

    idfw_pkg::idfw_state_t state_q;
    idfw_pkg::idfw_state_t state_d;
    logic [7:0] idx_q;
    logic [7:0] idx_d;
    logic hit_q;
    logic hit_d;
    logic rom_rd_en;
    logic [15:0] rom_data;
    logic [15:0] word_fixed;
    logic rd_ack_d;
    logic [15:0] rd_data_d;
    logic rd_hit_d;
    logic busy_d;
    logic wr_reject_d;
    logic ver_reported_d;
    logic minor_rev_d;
    logic sig_ok_d;
    logic [3:0] major_revs_d;
    logic take;

    // a read is taken only when idle
    assign take = rd_req && (state_q == idfw_pkg::ST_IDLE);
    assign rom_rd_en = take && idfw_in_slice(word_idx);

    // constant table; its contents never change after reset
    idfw_rom u_rom (
        .clk(clk),
        .rst_n(rst_n),
        .rd_en(rom_rd_en),
        .addr(idfw_to_addr(word_idx)),
        .data_q(rom_data)
    );

    // pin the fixed-meaning bits so the answer holds them whatever the table says
    always_comb begin
        word_fixed = rom_data;
        if (idx_q == idfw_pkg::IDX_CMD1) begin
            word_fixed[idfw_pkg::C1_PACKET] = 1'b0;
        end else if (idx_q == idfw_pkg::IDX_CMD2 || idx_q == idfw_pkg::IDX_EXT) begin
            word_fixed[idfw_pkg::SIG_ZERO_BIT] = 1'b0;
            word_fixed[idfw_pkg::SIG_ONE_BIT] = 1'b1;
        end else if (idx_q <= idfw_pkg::IDX_RSV_LAST) begin
            word_fixed = idfw_pkg::VAL_RESERVED;
        end
    end

    // controller next state
    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        hit_d = hit_q;
        case (state_q)
            idfw_pkg::ST_IDLE: begin
                if (rd_req) begin
                    idx_d = word_idx;
                    hit_d = idfw_in_slice(word_idx);
                    state_d = idfw_pkg::ST_FETCH;
                end
            end
            idfw_pkg::ST_FETCH: begin
                state_d = idfw_pkg::ST_ANSWER;
            end
            idfw_pkg::ST_ANSWER: begin
                state_d = idfw_pkg::ST_IDLE;
            end
            default: begin
                state_d = idfw_pkg::ST_IDLE;
            end
        endcase
    end

    // controller registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= idfw_pkg::ST_IDLE;
            idx_q <= idfw_pkg::IDX_FIRST;
            hit_q <= 1'b0;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            hit_q <= hit_d;
        end
    end

    // answer and status next values
    always_comb begin
        rd_ack_d = 1'b0;
        rd_data_d = rd_data_q;
        rd_hit_d = rd_hit_q;
        ver_reported_d = ver_reported_q;
        minor_rev_d = minor_rev_q;
        sig_ok_d = sig_ok_q;
        major_revs_d = major_revs_q;
        busy_d = (state_d != idfw_pkg::ST_IDLE);
        // writes land on constants, so they are refused and store nothing
        wr_reject_d = wr_req;
        if (state_q == idfw_pkg::ST_FETCH) begin
            rd_ack_d = 1'b1;
            rd_hit_d = hit_q;
            // outside the slice the answer is zero and no status is decoded
            rd_data_d = hit_q ? word_fixed : idfw_pkg::VAL_RESERVED;
            ver_reported_d = 1'b0;
            minor_rev_d = 1'b0;
            sig_ok_d = 1'b0;
            major_revs_d = 4'h0;
            if (hit_q && idx_q == idfw_pkg::IDX_MAJOR) begin
                ver_reported_d = !idfw_ver_none(word_fixed);
                if (!idfw_ver_none(word_fixed)) begin
                    major_revs_d = word_fixed[idfw_pkg::MAJ_REV_HI:idfw_pkg::MAJ_REV_LO];
                end
            end else if (hit_q && idx_q == idfw_pkg::IDX_MINOR) begin
                ver_reported_d = !idfw_ver_none(word_fixed);
                minor_rev_d = !idfw_ver_none(word_fixed);
            end else if (hit_q && idx_q == idfw_pkg::IDX_CMD1) begin
                // feature word without a signature; always trusted
                sig_ok_d = 1'b1;
            end else if (hit_q && (idx_q == idfw_pkg::IDX_CMD2 || idx_q == idfw_pkg::IDX_EXT)) begin
                sig_ok_d = !word_fixed[idfw_pkg::SIG_ZERO_BIT]
                    && word_fixed[idfw_pkg::SIG_ONE_BIT];
            end
        end
    end

    // answer and status registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_ack_q <= 1'b0;
            rd_data_q <= idfw_pkg::VAL_RESERVED;
            rd_hit_q <= 1'b0;
            busy_q <= 1'b0;
            wr_reject_q <= 1'b0;
            ver_reported_q <= 1'b0;
            minor_rev_q <= 1'b0;
            sig_ok_q <= 1'b0;
            major_revs_q <= 4'h0;
        end else begin
            rd_ack_q <= rd_ack_d;
            rd_data_q <= rd_data_d;
            rd_hit_q <= rd_hit_d;
            busy_q <= busy_d;
            wr_reject_q <= wr_reject_d;
            ver_reported_q <= ver_reported_d;
            minor_rev_q <= minor_rev_d;
            sig_ok_q <= sig_ok_d;
            major_revs_q <= major_revs_d;
        end
    end

endmodule // idfw_top

// >>> verif/idfw_assertions.sv
/*
 * checker for the identification feature words slice: answer timing,
 * fixed word values and write refusal.
 * assumes only the ports of idfw_top; attached by the bind below.
 */
module idfw_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // requests
    input wire logic rd_req,
    input wire logic [7:0] word_idx,
    input wire logic wr_req,
    input wire logic [15:0] wr_data,
    // answers and status
    input wire logic rd_ack_q,
    input wire logic [15:0] rd_data_q,
    input wire logic rd_hit_q,
    input wire logic busy_q,
    input wire logic wr_reject_q,
    input wire logic ver_reported_q,
    input wire logic minor_rev_q,
    input wire logic sig_ok_q,
    input wire logic [3:0] major_revs_q
);
    timeunit 1ns;
    timeprecision 1ns;

    logic take;
    logic [7:0] idx_d;
    logic [7:0] idx_q;

    // a read is taken only while idle
    assign take = rd_req && !busy_q;

    // index of the last taken read
    always_comb begin
        idx_d = take ? word_idx : idx_q;
    end
    always_ff @(posedge clk) begin
        idx_q <= rst_n ? idx_d : 8'h00;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // one fetch cycle, then the answer strobe in the last busy cycle, then idle
    sequence s_fetch;
        busy_q && !rd_ack_q;
    endsequence
    sequence s_answer;
        busy_q && rd_ack_q;
    endsequence

    a_answer_timing: assert property (take |=> s_fetch ##1 s_answer ##1 (!busy_q && !rd_ack_q))
        else $error("read answer not two cycles after take");
    a_spare_zero: assert property (rd_ack_q && idx_q inside {[8'h4c:8'h4f]} |-> rd_data_q == 16'h0000 && rd_hit_q)
        else $error("spare word not zero");
    a_version_none: assert property (rd_ack_q && idx_q inside {8'h50, 8'h51} |->
        rd_data_q == 16'h0000 && !ver_reported_q && !minor_rev_q && major_revs_q == 4'h0)
        else $error("version word reported");
    a_word82_value: assert property (rd_ack_q && idx_q == 8'h52 |-> rd_data_q == 16'h7028 && sig_ok_q)
        else $error("first feature word wrong");
    a_packet_clear: assert property (rd_ack_q && idx_q == 8'h52 |-> !rd_data_q[4])
        else $error("packet bit set");
    a_sig_bits: assert property (rd_ack_q && idx_q inside {8'h53, 8'h54} |-> rd_data_q[15:14] == 2'b01 && sig_ok_q)
        else $error("validity bits wrong");
    a_word83_value: assert property (rd_ack_q && idx_q == 8'h53 |-> rd_data_q == 16'h500c)
        else $error("second feature word wrong");
    a_word84_value: assert property (rd_ack_q && idx_q == 8'h54 |-> rd_data_q == 16'h4000)
        else $error("extension word wrong");
    a_write_reject: assert property (wr_req |=> wr_reject_q)
        else $error("write not refused");
    a_reject_cause: assert property (wr_reject_q |-> $past(wr_req))
        else $error("refusal without write");
    a_data_holds: assert property (!rd_ack_q && $past(rst_n) |-> $stable(rd_data_q))
        else $error("answer changed without a read");
endmodule // idfw_assertions

bind idfw_top idfw_assertions u_chk (.clk(clk), .rst_n(rst_n), .rd_req(rd_req), .word_idx(word_idx),
    .wr_req(wr_req), .wr_data(wr_data), .rd_ack_q(rd_ack_q), .rd_data_q(rd_data_q), .rd_hit_q(rd_hit_q),
    .busy_q(busy_q), .wr_reject_q(wr_reject_q), .ver_reported_q(ver_reported_q),
    .minor_rev_q(minor_rev_q), .sig_ok_q(sig_ok_q), .major_revs_q(major_revs_q));

// >>> verif/idfw_host_model.sv
/*
 * host reading identification words: one-cycle request, bounded wait for the answer.
 * assumes the slice clock; requests are driven at rising edges.
 */
module idfw_host_model (
    // clock
    input wire logic clk,
    // answer from the slice
    input wire logic rd_ack_q,
    input wire logic [15:0] rd_data_q,
    // request to the slice
    output logic rd_req,
    output logic [7:0] word_idx
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle at time zero
    initial begin
        rd_req = 1'b0;
        word_idx = 8'h00;
    end

    // stall gap + 1 cycles, pulse the request, then wait up to 8 cycles
    task automatic rd_word(input logic [7:0] idx, input int gap, output logic [15:0] data);
        data = 16'hxxxx;
        repeat (gap + 1) @(posedge clk);
        rd_req <= 1'b1;
        word_idx <= idx;
        @(posedge clk);
        rd_req <= 1'b0;
        word_idx <= ~idx; // released index does not keep the last value
        for (int n = 0; n < 8; n++) begin
            @(posedge clk);
            if (rd_ack_q === 1'b1) begin
                data = rd_data_q;
                break;
            end
        end
    endtask
endmodule // idfw_host_model

// >>> verif/tb_top.sv
/*
 * self-checking bench for the identification feature words slice.
 * assumes the host model drives reads and this module drives writes and reset.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk;
    logic rst_n;
    logic rd_req;
    logic [7:0] word_idx;
    logic wr_req;
    logic [15:0] wr_data;
    logic rd_ack_q;
    logic [15:0] rd_data_q;
    logic rd_hit_q;
    logic busy_q;
    logic wr_reject_q;
    logic ver_reported_q;
    logic minor_rev_q;
    logic sig_ok_q;
    logic [3:0] major_revs_q;
    int bad_count = 0;
    int checked = 0;

    // 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    idfw_top DUT (.clk(clk), .rst_n(rst_n), .rd_req(rd_req), .word_idx(word_idx), .wr_req(wr_req),
        .wr_data(wr_data), .rd_ack_q(rd_ack_q), .rd_data_q(rd_data_q), .rd_hit_q(rd_hit_q), .busy_q(busy_q),
        .wr_reject_q(wr_reject_q), .ver_reported_q(ver_reported_q), .minor_rev_q(minor_rev_q),
        .sig_ok_q(sig_ok_q), .major_revs_q(major_revs_q));
    idfw_host_model host (.clk(clk), .rd_ack_q(rd_ack_q), .rd_data_q(rd_data_q), .rd_req(rd_req),
        .word_idx(word_idx));

    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // counts, verdict, end of run
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // expected word for an index
    function automatic logic [15:0] word_of(input logic [7:0] idx);
        case (idx)
            8'h52: return 16'h7028;
            8'h53: return 16'h500c;
            8'h54: return 16'h4000;
            default: return 16'h0000;
        endcase
    endfunction

    // every word of the slice and one either side, with status
    task automatic test_words(input int gap);
        logic [15:0] d;
        for (logic [7:0] i = 8'h4b; i <= 8'h55; i++) begin
            host.rd_word(i, gap, d);
            #1;
            check(d, word_of(i));
            check(16'(rd_hit_q), 16'(i >= 8'h4c && i <= 8'h54));
            check(16'({ver_reported_q, minor_rev_q, major_revs_q}), 16'h0000);
            check(16'(sig_ok_q), 16'(i >= 8'h52 && i <= 8'h54));
            check(16'(d[4]), 16'h0000);
        end
        $display("test_words gap %0d done", gap);
    endtask

    // back-to-back writes, also across a read, change nothing
    task automatic test_writes();
        logic [15:0] d;
        @(posedge clk);
        wr_data <= 16'hffff;
        wr_req <= 1'b1;
        repeat (2) begin
            @(posedge clk);
            #1;
            check(16'(wr_reject_q), 16'h0001);
        end
        @(posedge clk);
        wr_data <= 16'h1234;
        host.rd_word(8'h52, 0, d);
        check(d, 16'h7028);
        wr_req <= 1'b0;
        @(posedge clk);
        #1;
        check(16'(wr_reject_q), 16'h0000);
        host.rd_word(8'h52, 0, d);
        check(d, 16'h7028);
        $display("test_writes done");
    endtask

    // reset in mid-run clears the answer, ack, hit, busy, signature and refusal outputs
    task automatic test_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check(rd_data_q, 16'h0000);
        check(16'({rd_ack_q, rd_hit_q, busy_q, sig_ok_q, wr_reject_q}), 16'h0000);
        $display("test_reset done");
    endtask

    // main sequence
    initial begin
        rst_n = 1'b0;
        wr_req = 1'b0;
        wr_data = 16'h0000;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        test_words(0);
        test_writes();
        test_reset();
        test_words(5);
        stop_test();
    end

    // watchdog well beyond the expected run of under two hundred cycles
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        $display("ERROR %0t: watchdog expired", $time);
        stop_test();
    end
endmodule // tb_top
